// *** hw/gpio_port.sv ***
// 8-bit general-purpose port with pin view and direction registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - pin view is read-only, writes ignored
// - read gives latch for outputs, pin otherwise
// - input reads ignore input buffer control
// - pin view has no reset value
// - direction write-only, read gives fixed filler
// - direction bit 1 drives where function select bit is 1, 0 inputs
module gpio_port (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [23:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [7:0]  o_rdata,
    input  wire logic [7:0]  i_pin,
    output logic      [7:0]  o_pin,
    output logic      [7:0]  o_pin_oe_n,
    output logic      [7:0]  o_ibuf_en
);
    ////////////////////////////////////////////////////////////////////////
    // decode
    gpio_port_pkg::bus_req_type  req;
    gpio_port_pkg::reg_sel_type  sel;
    logic [7:0]                  pin_sync_lvl;
    logic [7:0]                  direction_ff;
    logic [7:0]                  out_latch_ff;
    logic [7:0]                  ibuf_ctrl_ff;
    logic [7:0]                  func_sel_ff;
    logic [7:0]                  rdata_ff;
    logic [7:0]                  pin_view;
    logic [7:0]                  drive_en;
    logic [7:0]                  nxt_rdata;
    logic                        wr_direction;
    logic                        wr_out_latch;
    logic                        wr_ibuf_ctrl;
    logic                        wr_func_sel;

    function automatic gpio_port_pkg::reg_sel_type decode(
        input logic [23:0] addr
    );
        if (addr == gpio_port_pkg::ADDR_DIRECTION) begin
            decode = gpio_port_pkg::SEL_DIRECTION;
        end else if (addr == gpio_port_pkg::ADDR_PIN_VIEW) begin
            decode = gpio_port_pkg::SEL_PIN_VIEW;
        end else if (addr == gpio_port_pkg::ADDR_OUT_LATCH) begin
            decode = gpio_port_pkg::SEL_OUT_LATCH;
        end else if (addr == gpio_port_pkg::ADDR_IBUF_CTRL) begin
            decode = gpio_port_pkg::SEL_IBUF_CTRL;
        end else if (addr == gpio_port_pkg::ADDR_FUNC_SEL) begin
            decode = gpio_port_pkg::SEL_FUNC_SEL;
        end else begin
            decode = gpio_port_pkg::SEL_NONE;
        end
    endfunction

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign sel = decode(req.addr);

    ////////////////////////////////////////////////////////////////////////
    // pin input synchronisation
    pin_sync pin_sync_inst (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (i_pin),
        .o_sync  (pin_sync_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // write enables; the pin view has none, so a write there stores nothing
    assign wr_direction = req.wr
                       && (sel == gpio_port_pkg::SEL_DIRECTION);
    assign wr_out_latch = req.wr
                       && (sel == gpio_port_pkg::SEL_OUT_LATCH);
    assign wr_ibuf_ctrl = req.wr
                       && (sel == gpio_port_pkg::SEL_IBUF_CTRL);
    assign wr_func_sel  = req.wr
                       && (sel == gpio_port_pkg::SEL_FUNC_SEL);

    ////////////////////////////////////////////////////////////////////////
    // writable registers, one short block each
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            direction_ff <= gpio_port_pkg::RST_DIRECTION;
        end else if (wr_direction) begin
            direction_ff <= req.wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            out_latch_ff <= gpio_port_pkg::RST_OUT_LATCH;
        end else if (wr_out_latch) begin
            out_latch_ff <= req.wdata;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ibuf_ctrl_ff <= gpio_port_pkg::RST_IBUF_CTRL;
        end else if (wr_ibuf_ctrl) begin
            ibuf_ctrl_ff <= req.wdata;
        end
    end

    // resets to general i/o on every bit, so direction alone decides drive
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            func_sel_ff <= gpio_port_pkg::RST_FUNC_SEL;
        end else if (wr_func_sel) begin
            func_sel_ff <= req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-bit pin view and drive; bit b of every register belongs to pin b
    for (genvar b = 0; b < gpio_port_pkg::DATA_W; b++) begin : g_bit
        // view is computed live, never stored, so reset leaves no value
        // of its own behind; input buffer control is deliberately no term
        assign pin_view[b] = direction_ff[b]
                           ? out_latch_ff[b]
                           : pin_sync_lvl[b];
        // drive only where general i/o is selected and the bit is output
        assign drive_en[b] = func_sel_ff[b] & direction_ff[b];
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; the direction setting is never exposed
    function automatic logic [7:0] read_word(
        input gpio_port_pkg::reg_sel_type rsel,
        input logic [7:0]                 view,
        input logic [7:0]                 latch,
        input logic [7:0]                 ibuf,
        input logic [7:0]                 func
    );
        if (rsel == gpio_port_pkg::SEL_PIN_VIEW) begin
            read_word = view;
        end else if (rsel == gpio_port_pkg::SEL_DIRECTION) begin
            read_word = gpio_port_pkg::DIRECTION_RDVAL;
        end else if (rsel == gpio_port_pkg::SEL_OUT_LATCH) begin
            read_word = latch;
        end else if (rsel == gpio_port_pkg::SEL_IBUF_CTRL) begin
            read_word = ibuf;
        end else if (rsel == gpio_port_pkg::SEL_FUNC_SEL) begin
            read_word = func;
        end else begin
            read_word = gpio_port_pkg::UNMAPPED_RDVAL;
        end
    endfunction

    assign nxt_rdata = read_word(sel, pin_view, out_latch_ff, ibuf_ctrl_ff,
                                 func_sel_ff);

    // data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_ff <= 8'h00;
        end else if (req.rd) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive
    assign o_pin      = out_latch_ff;
    assign o_pin_oe_n = ~drive_en;
    assign o_ibuf_en  = ibuf_ctrl_ff;
    assign o_rdata    = rdata_ff;
endmodule // gpio_port
`default_nettype wire

// *** hw/gpio_port_pkg.sv ***
// constants and carrier types for the 8-bit gpio port
package gpio_port_pkg;
    localparam int          ADDR_W          = 24;
    localparam int          DATA_W          = 8;
    localparam int          SYNC_STAGES     = 2;
    // register byte addresses
    localparam logic [23:0] ADDR_DIRECTION  = 24'hfffb81;
    localparam logic [23:0] ADDR_PIN_VIEW   = 24'hffff40;
    localparam logic [23:0] ADDR_OUT_LATCH  = 24'hffff41;
    localparam logic [23:0] ADDR_IBUF_CTRL  = 24'hffff42;
    localparam logic [23:0] ADDR_FUNC_SEL   = 24'hffff43;
    // reset values
    localparam logic [7:0]  RST_DIRECTION   = 8'h00;
    localparam logic [7:0]  RST_OUT_LATCH   = 8'h00;
    localparam logic [7:0]  RST_IBUF_CTRL   = 8'h00;
    localparam logic [7:0]  RST_FUNC_SEL    = 8'hff;
    // value answered by a read of the write-only direction register
    localparam logic [7:0]  DIRECTION_RDVAL = 8'h00;
    localparam logic [7:0]  UNMAPPED_RDVAL  = 8'h00;

    typedef struct packed {
        logic [23:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bus_req_type;

    typedef enum {
        SEL_NONE,
        SEL_DIRECTION,
        SEL_PIN_VIEW,
        SEL_OUT_LATCH,
        SEL_IBUF_CTRL,
        SEL_FUNC_SEL
    } reg_sel_type;
endpackage

// *** hw/pin_sync.sv ***
// two-flop synchroniser for the port pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_async,
    output logic      [7:0] o_sync
);
    logic [7:0] meta_ff;
    logic [7:0] sync_ff;

    // first stage feeds only the second
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_ff <= 8'h00;
            sync_ff <= 8'h00;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule // pin_sync
`default_nettype wire

// *** sim/gpio_port_monitor.sv ***
// concurrent checks on the gpio port ports
`timescale 1ns/1ps
`default_nettype none
module gpio_port_monitor (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [23:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [7:0]  o_rdata,
    input  wire logic [7:0]  i_pin,
    input  wire logic [7:0]  o_pin,
    input  wire logic [7:0]  o_pin_oe_n
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire at_pin_view  = i_addr == gpio_port_pkg::ADDR_PIN_VIEW;
    wire at_direction = i_addr == gpio_port_pkg::ADDR_DIRECTION;
    wire at_latch     = i_addr == gpio_port_pkg::ADDR_OUT_LATCH;
    property p_pv_wr;
        i_wr && at_pin_view |=> $stable(o_pin) && $stable(o_pin_oe_n);
    endproperty
    a_pv_wr:
        assert property (p_pv_wr) else $error("pin view write had effect");
    // each bit is latch or pin; driven bits must be latch
    property p_pv_rd;
        i_rd && at_pin_view && !$past(i_rst) && !$past(i_rst, 2)
        && $stable(i_pin)
        && i_pin == $past(i_pin, 2) |=> ((o_rdata ^ o_pin)
        & ((o_rdata ^ $past(i_pin)) | ~o_pin_oe_n)) == 8'h00;
    endproperty
    a_pv_rd:
        assert property (p_pv_rd) else $error("pin view read wrong");
    property p_dir_rd;
        i_rd && at_direction |=> o_rdata == gpio_port_pkg::DIRECTION_RDVAL;
    endproperty
    a_dir_rd:
        assert property (p_dir_rd) else $error("direction read wrong");
    property p_dir_wr;
        i_wr && at_direction |=> (~o_pin_oe_n & ~$past(i_wdata)) == 8'h00;
    endproperty
    a_dir_wr:
        assert property (p_dir_wr) else $error("input bit driven");
    property p_lat_wr;
        i_wr && at_latch |=> o_pin == $past(i_wdata);
    endproperty
    a_lat_wr:
        assert property (p_lat_wr) else $error("latch not on pins");
    property p_idle;
        !i_rd |=> o_rdata == 8'h00;
    endproperty
    a_idle:
        assert property (p_idle) else $error("read data outside slot");
endmodule // gpio_port_monitor
bind gpio_port gpio_port_monitor gpio_port_monitor_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin), .o_pin(o_pin),
    .o_pin_oe_n(o_pin_oe_n));
`default_nettype wire

// *** sim/pin_board.sv ***
// board side of the port pins: driven bits echo, others take board level
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    input  wire logic [7:0] i_drv,
    input  wire logic [7:0] i_oe_n,
    input  wire logic [7:0] i_ext,
    output logic      [7:0] o_level
);
    assign o_level = (i_drv & ~i_oe_n) | (i_ext & i_oe_n);
endmodule // pin_board
`default_nettype wire

// *** sim/port_pin_read_direction_tb_top.sv ***
// self-checking bench for the gpio port
`timescale 1ns/1ps
`default_nettype none
module port_pin_read_direction_tb_top;
    logic        i_clk = 1'h0, i_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
    logic [23:0] i_addr = 24'h000000;
    logic [7:0]  i_wdata = 8'h00, ext = 8'h00;
    wire  [7:0]  o_rdata, o_pin, o_pin_oe_n, o_ibuf_en, lvl;
    int          err_total = 0, n_checks = 0, cyc = 0;
    gpio_port gpio_port_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_pin(lvl), .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n),
        .o_ibuf_en(o_ibuf_en));
    pin_board pin_board_inst (.i_drv(o_pin), .i_oe_n(o_pin_oe_n),
        .i_ext(ext), .o_level(lvl));
    initial forever #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [23:0] a, input logic [7:0] d);
        @(posedge i_clk) {i_addr, i_wdata, i_wr} <= {a, d, 1'h1};
        @(posedge i_clk) i_wr <= 1'h0;
        #1;
    endtask
    task rd(input logic [23:0] a, input logic [7:0] e);
        @(posedge i_clk) {i_addr, i_rd} <= {a, 1'h1};
        @(posedge i_clk) i_rd <= 1'h0;
        #1 chk("rdata", o_rdata, e);
    endtask
    // pins pass two sync flops before a read may see them
    task pins(input logic [7:0] v);
        @(posedge i_clk) ext <= v;
        repeat (3) @(posedge i_clk);
    endtask
    task t_reset_pins;
        pins(8'h3c);
        rd(gpio_port_pkg::ADDR_PIN_VIEW, 8'h3c);
        pins(8'hc3);
        rd(gpio_port_pkg::ADDR_PIN_VIEW, 8'hc3);
    endtask
    task t_mixed;
        wr(gpio_port_pkg::ADDR_OUT_LATCH, 8'ha5);
        chk("pin", o_pin, 8'ha5);
        wr(gpio_port_pkg::ADDR_DIRECTION, 8'h0f);
        chk("oe_n", o_pin_oe_n, 8'hf0);
        wr(gpio_port_pkg::ADDR_FUNC_SEL, 8'h00);
        chk("oe_n", o_pin_oe_n, 8'hff);
        pins(8'h5a);
        rd(gpio_port_pkg::ADDR_PIN_VIEW, 8'h55);
        rd(gpio_port_pkg::ADDR_DIRECTION,
           gpio_port_pkg::DIRECTION_RDVAL);
        wr(gpio_port_pkg::ADDR_IBUF_CTRL, 8'hff);
        chk("ibuf", o_ibuf_en, 8'hff);
        rd(gpio_port_pkg::ADDR_PIN_VIEW, 8'h55);
    endtask
    task t_protect;
        wr(gpio_port_pkg::ADDR_PIN_VIEW, 8'hff);
        wr(24'h000000, 8'hff);
        rd(gpio_port_pkg::ADDR_OUT_LATCH, 8'ha5);
        rd(24'h000000, gpio_port_pkg::UNMAPPED_RDVAL);
        wr(gpio_port_pkg::ADDR_FUNC_SEL, 8'hff);
        chk("oe_n", o_pin_oe_n, 8'hf0);
        rd(gpio_port_pkg::ADDR_PIN_VIEW, 8'h55);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'h0;
        t_reset_pins();
        t_mixed();
        t_protect();
        give_verdict();
    end
endmodule // port_pin_read_direction_tb_top
`default_nettype wire
